// ==== rtl/range_search.sv ====
/*
 * Automatic oscillator range search: a rising edge of the enable bit
 * starts a sweep whose end result is latched for the status page.
 * Assumes the enable comes from a register in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "reader_status_test_map.svh"

module range_search
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       auto_en,
    input  wire logic [3:0] range_target,
    output logic [3:0]      range_result,
    output logic            busy
);
    import reader_status_test_pkg::*;

    range_state_type state_q;    // search state
    logic            auto_en_q;  // previous enable level
    logic [4:0]      cnt_q;      // sweep step counter
    logic            start;      // rising edge of enable

    assign start = auto_en & ~auto_en_q;
    assign busy  = (state_q == rs_search);

    // enable history for edge detection
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            auto_en_q <= 1'b0;
        else
            auto_en_q <= auto_en;
    end

    // sweep through the segments; result settles at the target
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q      <= rs_idle;
            cnt_q        <= 5'h00;
            range_result <= 4'h0;
        end
        else
        begin
            case (state_q)
                rs_idle, rs_done:
                begin
                    if (start)
                    begin
                        state_q <= rs_search;
                        cnt_q   <= 5'h00;
                    end
                end
                rs_search:
                begin
                    range_result <= cnt_q[3:0];
                    if (cnt_q[3:0] == range_target || cnt_q == `RANGE_SEARCH_CYCLES - 5'h01)
                        state_q <= rs_done;
                    cnt_q <= cnt_q + 5'h01;
                end
                default:
                    state_q <= rs_idle;
            endcase
        end
    end

    a_search_ends: assert property (@(posedge clk) disable iff (!rstn)
        start && !busy |=> busy ##[1:16] !busy)
        else $error("range search did not end");
endmodule
`default_nettype wire

// ==== rtl/reader_status_test_map.svh ====
/*
 * Register offsets, field positions and reset values of the reader
 * status and test register group.
 * Assumes inclusion by bare name from rtl/ sources.
 */
`ifndef READER_STATUS_TEST_MAP_SVH
`define READER_STATUS_TEST_MAP_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_GAIN_INTERNAL_STATUS 5'h0e
`define IDX_SIGNAL_STRENGTH      5'h0f
`define IDX_LOOP_GAIN_VCO_STATUS 5'h10
`define IDX_ADC_SOURCE_SELECT    5'h11
`define IDX_TEST_SETTING         5'h12
`define IDX_CHIP_VERSION         5'h13
`define IDX_VCO_CONTROL          5'h14

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define RST_ADC_SOURCE_SELECT    8'h00
`define RST_TEST_SETTING         24'h000000
`define RST_VCO_CONTROL          24'h000000
`define TS_PAGE_HI               15
`define TS_PAGE_LO               14
`define TS_DECODER_SPEEDUP       16
`define VC_AUTO_RANGE_BIT        15
`define PAGE_LOOP_GAIN           2'h0
`define PAGE_VCO                 2'h1
`define MSEL_WIDTH               3
`define RANGE_SEARCH_CYCLES      5'h10

`endif

// ==== rtl/reader_status_test_pkg.sv ====
/*
 * Types shared by the reader status and test register group.
 * Assumes nothing of its surroundings.
 */
package reader_status_test_pkg;
    // adc input source codes
    typedef enum logic [2:0]
    {
        msel_none     = 3'h0,
        msel_i_mixer  = 3'h1,
        msel_q_mixer  = 3'h2,
        msel_adc_pin  = 3'h3,
        msel_rf_level = 3'h4,
        msel_ext_sup  = 3'h7
    } adc_source_type;

    // automatic range search states, gray along the usual path
    typedef enum logic [1:0]
    {
        rs_idle   = 2'b00,
        rs_search = 2'b01,
        rs_done   = 2'b11
    } range_state_type;
endpackage

// ==== rtl/reader_status_test_regs.sv ====
/*
 * Status and test register group of a reader front end, Avalon-MM slave.
 * Assumes analog status levels arrive synchronous to clk; chip enable low
 * acts as a synchronous clear of the writable registers.
 */
//
// Contract
// - gain step in status bits 7:4
// - bit 3 shows decoder channel, held
// - bits 2:0 flag rf, lock, oscillator
// - strength: q high nibble, i low
// - strength valid reception start to transmit
// - page field selects loop gain or vco
// - loop-gain page: i 5:3, q 2:0
// - vco page: range, type, pin voltage
// - read-only version register at 0x13
// - three-bit field selects adc source
// - source select clears on reset, enable
// - test setting three bytes, clears likewise
// - bit 16 speeds decoder, 17 reserved
// - rising auto bit starts range search
`timescale 1ns/1ps
`default_nettype none
`include "reader_status_test_map.svh"

module reader_status_test_regs
#(
    parameter logic [7:0] VERSION_CODE = 8'h5a  // arbitrary value
)
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        chip_en,
    input  wire logic [6:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [3:0]  gain_step,
    input  wire logic        dec_channel_q,
    input  wire logic        rx_start,
    input  wire logic        tx_start,
    input  wire logic        rf_level_stable,
    input  wire logic        synth_locked,
    input  wire logic        xtal_stable,
    input  wire logic [3:0]  strength_q,
    input  wire logic [3:0]  strength_i,
    input  wire logic [2:0]  loop_gain_i,
    input  wire logic [2:0]  loop_gain_q,
    input  wire logic        vco_type_1800,
    input  wire logic [2:0]  vco_pin_voltage,
    input  wire logic [3:0]  range_target,
    output logic [2:0]       adc_source,
    output logic             decoder_speedup,
    output logic [5:0]       analog_test,
    output logic [1:0]       status_page_sel,
    output logic             range_busy
);
    import reader_status_test_pkg::*;

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [7:0]  adc_sel_q;       // measurement source register
    logic [23:0] test_q;          // test setting register
    logic [23:0] vco_ctrl_q;      // oscillator control register
    logic        chan_q;          // decoder channel snapshot
    logic [7:0]  strength_q_r;    // strength snapshot
    logic        rx_window_q;     // between reception and transmit
    logic        ack_q;           // one-cycle answer
    logic [4:0]  idx;             // register index
    logic        wr_hit;          // write accepted now
    logic [7:0]  gain_stat;       // assembled status byte
    logic [7:0]  paged_stat;      // paged status byte
    logic [31:0] rd_mux;          // read data selection
    logic [3:0]  range_result;    // search result
    logic        busy_w;          // search running
    logic [23:0] wmask;           // byte lane write mask

    assign idx    = avs_address[6:2];
    // a write lands at the answering edge, where the master sees
    // waitrequest low; the first cycle only arms the answer
    assign wr_hit = avs_write & ack_q;
    assign wmask  = {{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // ****************************************************************
    // bus handshake: one wait state, answer in the second cycle
    // ****************************************************************
    // waitrequest stands high until the answering cycle
    // cleared right after the answer, so a strobe held one cycle too
    // long starts a fresh transfer instead of answering twice
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read | avs_write) & ~ack_q;
    end

    // waitrequest from a flop: low only in the answering cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
    end

    // ****************************************************************
    // writable registers
    // ****************************************************************
    // measurement source; only the low field is kept
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            adc_sel_q <= `RST_ADC_SOURCE_SELECT;
        else if (!chip_en)
            adc_sel_q <= `RST_ADC_SOURCE_SELECT;
        else if (wr_hit && idx == `IDX_ADC_SOURCE_SELECT && avs_byteenable[0])
            adc_sel_q <= {5'h00, avs_writedata[2:0]};
    end

    // test setting, per byte lane; bit 17 reserved reads zero
    // the bits reach the analog side only through the output flops,
    // so a test mode takes effect one cycle after the write
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            test_q <= `RST_TEST_SETTING;
        else if (!chip_en)
            test_q <= `RST_TEST_SETTING;
        else if (wr_hit && idx == `IDX_TEST_SETTING)
            test_q <= ((test_q & ~wmask) | (avs_writedata[23:0] & wmask)) & 24'hfdffff;
    end

    // oscillator control holding the auto range enable
    // only the auto bit is acted on here; the rest is plain storage
    // kept readable so software can read back what it wrote
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            vco_ctrl_q <= `RST_VCO_CONTROL;
        else if (!chip_en)
            vco_ctrl_q <= `RST_VCO_CONTROL;
        else if (wr_hit && idx == `IDX_VCO_CONTROL)
            vco_ctrl_q <= (vco_ctrl_q & ~wmask) | (avs_writedata[23:0] & wmask);
    end

    // ****************************************************************
    // reception window snapshots
    // ****************************************************************
    // window opens at reception start, closes at next transmit
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rx_window_q <= 1'b0;
        else if (rx_start)
            rx_window_q <= 1'b1;
        else if (tx_start)
            rx_window_q <= 1'b0;
    end

    // channel and strength follow the decoder only inside the window;
    // outside it the last values hold so software reads something stable
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            chan_q       <= 1'b0;
            strength_q_r <= 8'h00;
        end
        else if (rx_start || (rx_window_q && !tx_start))
        begin
            chan_q       <= dec_channel_q;
            strength_q_r <= {strength_q, strength_i};
        end
    end

    // ****************************************************************
    // status assembly and read path
    // ****************************************************************
    assign gain_stat = {gain_step, chan_q, rf_level_stable, synth_locked, xtal_stable};

    // paged status: codes other than the two defined read as zero
    always_comb
    begin
        case (test_q[`TS_PAGE_HI:`TS_PAGE_LO])
            `PAGE_LOOP_GAIN: paged_stat = {2'b00, loop_gain_i, loop_gain_q};
            `PAGE_VCO:       paged_stat = {range_result, vco_type_1800, vco_pin_voltage};
            default:         paged_stat = 8'h00;
        endcase
    end

    // read selection; reads never alter state
    // the vco control index sits past the status group; anything
    // above it or below the gain status reads as zero
    always_comb
    begin
        case (idx)
            `IDX_GAIN_INTERNAL_STATUS: rd_mux = {24'h000000, gain_stat};
            `IDX_SIGNAL_STRENGTH:      rd_mux = {24'h000000, strength_q_r};
            `IDX_LOOP_GAIN_VCO_STATUS: rd_mux = {24'h000000, paged_stat};
            `IDX_ADC_SOURCE_SELECT:    rd_mux = {24'h000000, adc_sel_q};
            `IDX_TEST_SETTING:         rd_mux = {8'h00, test_q};
            `IDX_CHIP_VERSION:         rd_mux = {24'h000000, VERSION_CODE};
            `IDX_VCO_CONTROL:          rd_mux = {8'h00, vco_ctrl_q};
            default:                   rd_mux = 32'h00000000;               // unmapped reads zero
        endcase
    end

    // read data registered, valid in the answering cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            avs_readdata <= 32'h00000000;
        else if (avs_read && !ack_q)
            avs_readdata <= rd_mux;
    end

    // ****************************************************************
    // range search and registered outputs
    // ****************************************************************
    // the search runs on its own; software polls the busy output or
    // the vco page to see where it settled
    range_search u_range_search
    (
        .clk          (clk),
        .rstn         (rstn),
        .auto_en      (vco_ctrl_q[`VC_AUTO_RANGE_BIT]),
        .range_target (range_target),
        .range_result (range_result),
        .busy         (busy_w)
    );

    // control outputs straight from flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            adc_source      <= 3'h0;
            decoder_speedup <= 1'b0;
            analog_test     <= 6'h00;
            status_page_sel <= 2'h0;
            range_busy      <= 1'b0;
        end
        else
        begin
            adc_source      <= adc_sel_q[2:0];
            decoder_speedup <= test_q[`TS_DECODER_SPEEDUP];
            analog_test     <= test_q[23:18];
            status_page_sel <= test_q[`TS_PAGE_HI:`TS_PAGE_LO];
            range_busy      <= busy_w;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // chip enable low clears the writable registers at the next edge
    a_enable_clears_sel: assert property (@(posedge clk) disable iff (!rstn)
        !chip_en |=> adc_sel_q == `RST_ADC_SOURCE_SELECT)
        else $error("source select not cleared");
    a_enable_clears_test: assert property (@(posedge clk) disable iff (!rstn)
        !chip_en |=> test_q == `RST_TEST_SETTING)
        else $error("test setting not cleared");

    // reserved bits can never be stored, whatever the host writes
    a_reserved_bit_zero: assert property (@(posedge clk) disable iff (!rstn)
        test_q[17] == 1'b0)
        else $error("reserved test bit set");
    a_sel_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
        adc_sel_q[7:3] == 5'h00)
        else $error("reserved select bits set");

    // read answers, held against the levels at the taking edge
    a_version_read: assert property (@(posedge clk) disable iff (!rstn)
        avs_read && !ack_q && idx == `IDX_CHIP_VERSION |=> avs_readdata == {24'h000000, VERSION_CODE})
        else $error("version read wrong");
    a_status_read: assert property (@(posedge clk) disable iff (!rstn)
        avs_read && !ack_q && idx == `IDX_GAIN_INTERNAL_STATUS
        |=> avs_readdata[7:4] == $past(gain_step) && avs_readdata[2] == $past(rf_level_stable))
        else $error("status read wrong");
    a_health_read: assert property (@(posedge clk) disable iff (!rstn)
        avs_read && !ack_q && idx == `IDX_GAIN_INTERNAL_STATUS
        |=> avs_readdata[3:0] == {$past(chan_q), $past(rf_level_stable), $past(synth_locked), $past(xtal_stable)})
        else $error("health bits read wrong");
    a_vco_read: assert property (@(posedge clk) disable iff (!rstn)
        avs_read && !ack_q && idx == `IDX_LOOP_GAIN_VCO_STATUS && test_q[15:14] == `PAGE_VCO
        |=> avs_readdata[7:0] == {$past(range_result), $past(vco_type_1800), $past(vco_pin_voltage)})
        else $error("vco page read wrong");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
        avs_read && !ack_q && (idx < `IDX_GAIN_INTERNAL_STATUS || idx > `IDX_VCO_CONTROL)
        |=> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_status_write_void: assert property (@(posedge clk) disable iff (!rstn)
        wr_hit && idx == `IDX_CHIP_VERSION |=> $stable(test_q) && $stable(adc_sel_q))
        else $error("status write had effect");
    a_read_no_effect: assert property (@(posedge clk) disable iff (!rstn)
        avs_read && chip_en |=> $stable(test_q) && $stable(adc_sel_q) && $stable(vco_ctrl_q))
        else $error("read changed a register");
    a_answer_one_wait: assert property (@(posedge clk) disable iff (!rstn)
        (avs_read || avs_write) && avs_waitrequest && !ack_q |=> !avs_waitrequest)
        else $error("bus answer late");

    // reception window and the snapshots taken inside it
    a_channel_snapshot: assert property (@(posedge clk) disable iff (!rstn)
        rx_start |=> chan_q == $past(dec_channel_q))
        else $error("channel not taken at reception start");
    a_strength_order: assert property (@(posedge clk) disable iff (!rstn)
        rx_start |=> strength_q_r == {$past(strength_q), $past(strength_i)})
        else $error("strength nibbles misplaced");
    a_strength_hold: assert property (@(posedge clk) disable iff (!rstn)
        !rx_window_q && !rx_start |=> $stable(strength_q_r) && $stable(chan_q))
        else $error("strength changed outside window");
    a_window_close: assert property (@(posedge clk) disable iff (!rstn)
        tx_start && !rx_start |=> !rx_window_q)
        else $error("window open after transmit start");

    // paged status and the registered control outputs
    a_page_loop_gain: assert property (@(posedge clk) disable iff (!rstn)
        test_q[15:14] == 2'h0 |-> paged_stat == {2'b00, loop_gain_i, loop_gain_q})
        else $error("loop gain page wrong");
    a_source_output: assert property (@(posedge clk) disable iff (!rstn)
        $stable(adc_sel_q) |-> adc_source == adc_sel_q[2:0])
        else $error("adc source output stale");
    a_test_outputs: assert property (@(posedge clk) disable iff (!rstn)
        $stable(test_q) |-> decoder_speedup == test_q[`TS_DECODER_SPEEDUP] && analog_test == test_q[23:18]
            && status_page_sel == test_q[`TS_PAGE_HI:`TS_PAGE_LO])
        else $error("test outputs do not follow register");

    // main scenarios worth seeing at least once
    c_vco_page: cover property (@(posedge clk) disable iff (!rstn)
        avs_read && !ack_q && idx == `IDX_LOOP_GAIN_VCO_STATUS && test_q[15:14] == 2'h1);
    c_rx_window: cover property (@(posedge clk) disable iff (!rstn) rx_start ##[1:20] tx_start);
    c_test_write: cover property (@(posedge clk) disable iff (!rstn) wr_hit && idx == `IDX_TEST_SETTING);
    c_search: cover property (@(posedge clk) disable iff (!rstn) $rose(busy_w));
    c_enable_clear: cover property (@(posedge clk) disable iff (!rstn) !chip_en ##1 chip_en);
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
/*
 * Host bus master model: Avalon-MM reads and writes to the register group.
 * Assumes one clock and a slave that answers through waitrequest.
 */
`timescale 1ns/1ps
`default_nettype none

module host_model
(
    input  wire logic        clk,
    output logic [6:0]       address,
    output logic             read,
    output logic             write,
    output logic [31:0]      writedata,
    output logic [3:0]       byteenable,
    input  wire logic        waitrequest
);
    // idle bus at time zero
    initial
    begin
        address    = 7'h00;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h0;
        byteenable = 4'h0;
    end

    // one transfer held until waitrequest samples low; to flags a hang
    task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d, output logic to);
        int n;
        n = 0;
        @(posedge clk);
        address    <= a;
        read       <= ~w;
        write      <= w;
        writedata  <= d;
        byteenable <= 4'hf;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        to = (n >= 50);
        read      <= 1'b0;
        write     <= 1'b0;
        // released data must not keep showing the last value
        writedata <= ~d;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench of the reader status and test register group.
 * Assumes the host model drives the bus; reads are checked from a queue.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import reader_status_test_pkg::*;
    localparam logic [7:0] VER = 8'h3c;  // arbitrary value
    logic        clk, rstn, chip_en, rd_s, wr_s, wreq, vt, dsp, busy, to;
    logic        dcq, rxs, txs, rfs, lck, xs;
    logic [6:0]  addr;
    logic [31:0] wdata, rdata, e, x, r;
    logic [3:0]  be, gain, sq, si, tgt;
    logic [2:0]  lgi, lgq, pin, adc;
    logic [5:0]  atst;
    logic [1:0]  pg;
    logic [31:0] expq[$];
    int          n_fail, comparisons, n;
    adc_source_type m;

    // free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    reader_status_test_regs #(.VERSION_CODE(VER)) dut
    (
        .clk(clk), .rstn(rstn), .chip_en(chip_en), .avs_address(addr),
        .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdata),
        .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .gain_step(gain), .dec_channel_q(dcq), .rx_start(rxs), .tx_start(txs),
        .rf_level_stable(rfs), .synth_locked(lck), .xtal_stable(xs),
        .strength_q(sq), .strength_i(si), .loop_gain_i(lgi), .loop_gain_q(lgq),
        .vco_type_1800(vt), .vco_pin_voltage(pin), .range_target(tgt),
        .adc_source(adc), .decoder_speedup(dsp), .analog_test(atst),
        .status_page_sel(pg), .range_busy(busy)
    );

    host_model host
    (
        .clk(clk), .address(addr), .read(rd_s), .write(wr_s),
        .writedata(wdata), .byteenable(be), .waitrequest(wreq)
    );

    task automatic fail(input string s);
        n_fail++;
        $display("[FAIL] %0t %s", $time, s);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        comparisons++;
        if (got !== exp)
            fail(s);
    endtask

    task automatic end_of_test();
        $display("counts: %0d comparisons, %0d failures", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // bus access; a read notes its expected data for the watcher
    task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d);
        if (!w)
            expq.push_back(d);
        host.xfer(w, a, d, to);
        if (to)
        begin
            fail("bus hang");
            end_of_test();
        end
    endtask

    // watcher: oldest note against each answered read
    always @(posedge clk)
    begin
        if (rd_s === 1'b1 && wreq === 1'b0)
        begin
            r = expq.pop_front();
            chk(rdata, r, "read data");
        end
    end

    initial
    begin
        n_fail = 0;
        comparisons = 0;
        {rstn, chip_en, gain, dcq, rxs, txs, rfs, lck, xs, sq, si} = '0;
        {lgi, lgq, vt, pin, tgt} = '0;
        void'($urandom(32'h6f09eab1));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        chip_en <= 1'b1;
        acc(1'b0, 7'h44, 32'h0);
        acc(1'b0, 7'h48, 32'h0);
        acc(1'b0, 7'h7c, 32'h0);
        acc(1'b0, 7'h4c, {24'h0, VER});
        $display("test reset values done");
        // status fields, then held across the transmit start
        for (int i = 0; i < 4; i++)
        begin
            {gain, dcq, rfs, lck, xs, sq, si} <= 16'($urandom);
            rxs <= 1'b1;
            @(posedge clk);
            rxs <= 1'b0;
            repeat (2) @(posedge clk);
            e = {24'h0, gain, dcq, rfs, lck, xs};
            x = {24'h0, sq, si};
            acc(1'b0, 7'h38, e);
            acc(1'b0, 7'h3c, x);
            txs <= 1'b1;
            @(posedge clk);
            txs <= 1'b0;
            {dcq, sq, si} <= ~{dcq, sq, si};
            repeat (2) @(posedge clk);
            acc(1'b0, 7'h38, e);
            acc(1'b0, 7'h3c, x);
        end
        $display("test status window done");
        {lgi, lgq, vt, pin, tgt} <= 14'($urandom);
        acc(1'b1, 7'h48, 32'h0);
        acc(1'b0, 7'h40, {26'h0, lgi, lgq});
        acc(1'b1, 7'h50, 32'h0000_8000);
        for (n = 0; n < 10 && busy !== 1'b1; n++)
            @(posedge clk);
        chk(busy, 1'b1, "range search start");
        if (busy !== 1'b1)
            end_of_test();
        for (n = 0; n < 40 && busy !== 1'b0; n++)
            @(posedge clk);
        if (busy !== 1'b0)
        begin
            fail("range search hang");
            end_of_test();
        end
        acc(1'b1, 7'h48, 32'h0000_4000);
        acc(1'b0, 7'h40, {24'h0, tgt, vt, pin});
        acc(1'b1, 7'h48, 32'h0000_8000);
        // write lands at the answering edge, the output flop one edge later
        repeat (2) @(posedge clk);
        chk(pg, 2'b10, "page select");
        acc(1'b0, 7'h40, 32'h0);
        $display("test paged status done");
        // every source code, reserved bits written high
        m = m.first();
        do
        begin
            acc(1'b1, 7'h44, {24'h0, 5'h1f, m});
            acc(1'b0, 7'h44, {29'h0, m});
            @(posedge clk);
            chk(adc, m, "adc source");
            m = m.next();
        end
        while (m != m.first());
        x = $urandom & 32'h00ff_ffff;
        acc(1'b1, 7'h48, x);
        acc(1'b0, 7'h48, x & 32'h00fd_ffff);
        @(posedge clk);
        chk({atst, dsp, pg}, {x[23:18], x[16], x[15:14]}, "test outputs");
        chip_en <= 1'b0;
        @(posedge clk);
        chip_en <= 1'b1;
        acc(1'b0, 7'h48, 32'h0);
        acc(1'b0, 7'h44, 32'h0);
        $display("test writable registers done");
        // writes to read-only places change nothing
        acc(1'b1, 7'h4c, 32'hffff_ffff);
        acc(1'b1, 7'h40, 32'hffff_ffff);
        acc(1'b1, 7'h38, 32'hffff_ffff);
        acc(1'b0, 7'h4c, {24'h0, VER});
        acc(1'b1, 7'h48, 32'h0);
        acc(1'b0, 7'h40, {26'h0, lgi, lgq});
        acc(1'b0, 7'h38, e);
        $display("test read-only done");
        end_of_test();
    end
endmodule
`default_nettype wire
